/* File: stack_pointer_tracker.sv */
// Purpose: track sp offset across stack instructions in the front end
// Assumes: execution reports the new sp value with wb_valid after an sp write
// Notes: out_offset is the offset to add to the last synced sp
`timescale 1ns/1ps
module stack_pointer_tracker #(
    parameter int OFFSET_W = sp_track_pkg::OFFSET_W
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic in_valid,
    output logic in_ready,
    input wire sp_track_pkg::sp_class_e in_class,
    input wire logic signed [OFFSET_W-1:0] in_delta,
    output logic out_valid,
    input wire logic out_ready,
    output sp_track_pkg::sp_class_e out_class,
    output logic signed [OFFSET_W-1:0] out_offset,
    output logic out_use_tracked,
    output logic out_wait_real_sp,
    input wire logic wb_valid,
    output logic resync_pending
);

    logic adjusts;
    logic uses_tracked;
    logic keeps_dep;
    logic writes_sp;
    logic take;
    logic out_free;
    logic signed [OFFSET_W-1:0] offset_r;
    logic signed [OFFSET_W-1:0] offset_nxt;
    logic signed [OFFSET_W-1:0] sum_w;
    sp_track_pkg::trk_state_e st_r;
    sp_track_pkg::trk_state_e st_nxt;
    logic out_valid_r;
    sp_track_pkg::sp_class_e out_class_r;
    logic signed [OFFSET_W-1:0] out_offset_r;
    logic out_use_tracked_r;
    logic out_wait_r;

    sp_class_decode u_dec (
        .cls(in_class),
        .adjusts(adjusts),
        .uses_tracked(uses_tracked),
        .keeps_dep(keeps_dep),
        .writes_sp(writes_sp)
    );

    // handshake: stall while an sp write is outstanding
    assign out_free = !out_valid_r || out_ready;
    assign in_ready = (st_r == sp_track_pkg::ST_RUN) && out_free;
    assign take = in_valid && in_ready;
    assign sum_w = offset_r + in_delta;

    // offset update
    always_comb begin
        offset_nxt = offset_r;
        if (st_r == sp_track_pkg::ST_WAIT_WB && wb_valid) begin
            offset_nxt = OFFSET_W'(sp_track_pkg::OFFSET_RST);
        end else if (take && adjusts) begin
            offset_nxt = sum_w;
        end else if (take && keeps_dep) begin
            offset_nxt = OFFSET_W'(sp_track_pkg::OFFSET_RST);
        end
    end

    // state update
    always_comb begin
        st_nxt = st_r;
        unique case (st_r)
            sp_track_pkg::ST_RUN: begin
                if (take && writes_sp) begin
                    st_nxt = sp_track_pkg::ST_WAIT_WB;
                end
            end
            sp_track_pkg::ST_WAIT_WB: begin
                if (wb_valid) begin
                    st_nxt = sp_track_pkg::ST_RUN;
                end
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            offset_r <= OFFSET_W'(sp_track_pkg::OFFSET_RST);
            st_r <= sp_track_pkg::ST_RUN;
        end else begin
            offset_r <= offset_nxt;
            st_r <= st_nxt;
        end
    end

    // issued instruction: offset seen before its own adjustment
    always_ff @(posedge clk) begin
        if (rst) begin
            out_valid_r <= 1'b0;
            out_class_r <= sp_track_pkg::CLS_OTHER;
            out_offset_r <= OFFSET_W'(sp_track_pkg::OFFSET_RST);
            out_use_tracked_r <= 1'b0;
            out_wait_r <= 1'b0;
        end else if (out_free) begin
            out_valid_r <= take;
            out_class_r <= in_class;
            out_offset_r <= offset_r;
            out_use_tracked_r <= take && uses_tracked;
            out_wait_r <= take && keeps_dep;
        end
    end

    assign out_valid = out_valid_r;
    assign out_class = out_class_r;
    assign out_offset = out_offset_r;
    assign out_use_tracked = out_use_tracked_r;
    assign out_wait_real_sp = out_wait_r;
    assign resync_pending = (st_r == sp_track_pkg::ST_WAIT_WB);

    // checks
    a_push_pop_track: assert property (@(posedge clk) disable iff (rst)
        (take && (in_class == sp_track_pkg::CLS_PUSH || in_class == sp_track_pkg::CLS_POP))
        |=> (offset_r == $past(sum_w)) && out_valid && out_use_tracked && !out_wait_real_sp)
        else $error("push or pop offset not tracked");

    a_call_ret_track: assert property (@(posedge clk) disable iff (rst)
        (take && in_class inside {sp_track_pkg::CLS_CALL, sp_track_pkg::CLS_RET,
                                  sp_track_pkg::CLS_TEARDOWN})
        |=> out_use_tracked && !out_wait_real_sp && in_ready == out_free)
        else $error("call, return or teardown serialised");

    a_src_resolve: assert property (@(posedge clk) disable iff (rst)
        (take && in_class inside {sp_track_pkg::CLS_SP_SRC, sp_track_pkg::CLS_SP_MEM_NOIDX})
        |=> out_use_tracked && out_offset == $past(offset_r) && offset_r == $past(offset_r))
        else $error("sp source not resolved through offset");

    a_addr_calc_dep: assert property (@(posedge clk) disable iff (rst)
        (take && in_class == sp_track_pkg::CLS_ADDR_CALC_SP)
        |=> out_wait_real_sp && !out_use_tracked && offset_r == '0)
        else $error("address calculation lost sp dependency");

    a_dst_hold: assert property (@(posedge clk) disable iff (rst)
        (take && in_class == sp_track_pkg::CLS_SP_DST)
        |=> out_wait_real_sp && resync_pending && !in_ready)
        else $error("sp destination write not held");

    a_index_dep: assert property (@(posedge clk) disable iff (rst)
        (take && in_class == sp_track_pkg::CLS_SP_MEM_IDX)
        |=> out_wait_real_sp && !out_use_tracked)
        else $error("indexed sp operand used tracked value");

    a_mcode_dep: assert property (@(posedge clk) disable iff (rst)
        (take && in_class == sp_track_pkg::CLS_MCODE_SP)
        |=> out_wait_real_sp && !out_use_tracked ##0 resync_pending)
        else $error("microcoded sp instruction used tracked value");

    a_resync_zero: assert property (@(posedge clk) disable iff (rst)
        (resync_pending && wb_valid) |=> !resync_pending && offset_r == '0)
        else $error("offset not resynced after sp write");

    a_wait_stall: assert property (@(posedge clk) disable iff (rst)
        resync_pending |-> !in_ready)
        else $error("tracking applied before resync");

    // pipe handshake and offset bookkeeping
    a_issue_next: assert property (@(posedge clk) disable iff (rst)
        take |=> out_valid && out_class == $past(in_class))
        else $error("taken instruction not issued next cycle");

    a_stall_hold: assert property (@(posedge clk) disable iff (rst)
        (out_valid && !out_ready) |=> out_valid && $stable(out_class) && $stable(out_offset)
        && $stable(out_use_tracked) && $stable(out_wait_real_sp))
        else $error("issued instruction changed while stalled");

    a_idle_drop: assert property (@(posedge clk) disable iff (rst)
        (out_free && !take) |=> !out_valid && !out_use_tracked && !out_wait_real_sp)
        else $error("issue slot not emptied when idle");

    a_offset_quiet: assert property (@(posedge clk) disable iff (rst)
        (!take && !(resync_pending && wb_valid)) |=> offset_r == $past(offset_r))
        else $error("offset moved with no instruction");

    a_call_ret_sum: assert property (@(posedge clk) disable iff (rst)
        (take && in_class inside {sp_track_pkg::CLS_CALL, sp_track_pkg::CLS_RET,
                                  sp_track_pkg::CLS_TEARDOWN})
        |=> offset_r == $past(offset_r) + $past(in_delta))
        else $error("call, return or teardown delta not applied");

    a_src_no_wait: assert property (@(posedge clk) disable iff (rst)
        (take && in_class inside {sp_track_pkg::CLS_SP_SRC, sp_track_pkg::CLS_SP_MEM_NOIDX})
        |=> !out_wait_real_sp && !resync_pending)
        else $error("sp source instruction held for real sp");

    a_other_plain: assert property (@(posedge clk) disable iff (rst)
        (out_valid && out_class == sp_track_pkg::CLS_OTHER) |-> !out_use_tracked && !out_wait_real_sp)
        else $error("unrelated instruction marked for sp handling");

    a_dst_offset: assert property (@(posedge clk) disable iff (rst)
        (take && in_class inside {sp_track_pkg::CLS_SP_DST, sp_track_pkg::CLS_MCODE_SP})
        |=> out_offset == $past(offset_r) && offset_r == '0)
        else $error("sp write did not hand over the pending offset");

    a_wait_hold: assert property (@(posedge clk) disable iff (rst)
        (resync_pending && !wb_valid) |=> resync_pending && offset_r == $past(offset_r))
        else $error("resync left before new sp arrived");

    a_resync_ready: assert property (@(posedge clk) disable iff (rst)
        (resync_pending && wb_valid) |=> in_ready || (out_valid && !out_ready))
        else $error("input not reopened after resync");

    a_ready_run: assert property (@(posedge clk) disable iff (rst)
        (!resync_pending && !(out_valid && !out_ready)) |-> in_ready)
        else $error("stack instruction serialised without cause");

    a_busy_refuse: assert property (@(posedge clk) disable iff (rst)
        (out_valid && !out_ready) |-> !in_ready)
        else $error("input taken while issue slot full");

    a_wait_no_track: assert property (@(posedge clk) disable iff (rst)
        (out_valid && out_wait_real_sp) |-> !out_use_tracked)
        else $error("dependent instruction also marked tracked");

    a_reset_state: assert property (@(posedge clk)
        rst |=> !out_valid && !resync_pending && offset_r == '0 && out_offset == '0)
        else $error("tracker not cleared by reset");

endmodule : stack_pointer_tracker

/* File: sp_track_pkg.sv */
// Purpose: shared constants and types for the stack pointer tracker
// Assumes: one instruction offered per cycle by the decoder
package sp_track_pkg;

    localparam int OFFSET_W = 16;
    localparam logic [OFFSET_W-1:0] OFFSET_RST = 16'h0000;
    localparam int CLASS_W = 4;

    // instruction classes as seen by the tracker
    typedef enum logic [CLASS_W-1:0] {
        CLS_OTHER,
        CLS_PUSH,
        CLS_POP,
        CLS_CALL,
        CLS_RET,
        CLS_TEARDOWN,
        CLS_SP_SRC,
        CLS_SP_MEM_NOIDX,
        CLS_ADDR_CALC_SP,
        CLS_SP_DST,
        CLS_SP_MEM_IDX,
        CLS_MCODE_SP
    } sp_class_e;

    typedef enum logic {
        ST_RUN,
        ST_WAIT_WB
    } trk_state_e;

endpackage : sp_track_pkg

/* File: sp_class_decode.sv */
// Purpose: classify an instruction class for the tracker
// Assumes: class code comes straight from the decoder
// Notes: purely combinational
`timescale 1ns/1ps
module sp_class_decode (
    input wire sp_track_pkg::sp_class_e cls,
    output logic adjusts,
    output logic uses_tracked,
    output logic keeps_dep,
    output logic writes_sp
);
    // stack adjusting classes
    function automatic logic is_adjust(input sp_track_pkg::sp_class_e c);
        return c inside {sp_track_pkg::CLS_PUSH, sp_track_pkg::CLS_POP,
                         sp_track_pkg::CLS_CALL, sp_track_pkg::CLS_RET,
                         sp_track_pkg::CLS_TEARDOWN};
    endfunction : is_adjust

    assign adjusts = is_adjust(cls);
    assign uses_tracked = is_adjust(cls) || cls == sp_track_pkg::CLS_SP_SRC
                          || cls == sp_track_pkg::CLS_SP_MEM_NOIDX;
    assign keeps_dep = cls inside {sp_track_pkg::CLS_ADDR_CALC_SP, sp_track_pkg::CLS_SP_DST,
                                   sp_track_pkg::CLS_SP_MEM_IDX,
                                   sp_track_pkg::CLS_MCODE_SP};
    assign writes_sp = cls == sp_track_pkg::CLS_SP_DST
                       || cls == sp_track_pkg::CLS_MCODE_SP;

endmodule : sp_class_decode

/* File: exec_model.sv */
// Purpose: execution side model for the stack pointer tracker
// Assumes: wb pulse reports the real sp a few cycles after an sp write issues
// Notes: stall holds off issue acceptance
`timescale 1ns/1ps
module exec_model (
    input wire logic clk,
    input wire logic rst,
    input wire logic stall,
    input wire logic resync_pending,
    output logic out_ready,
    output logic wb_valid
);
    logic [3:0] wait_cnt_r;
    // accept issue unless stalled
    assign out_ready = !stall;
    always_ff @(posedge clk) begin
        if (rst || !resync_pending) begin
            wait_cnt_r <= 4'h0;
        end else begin
            wait_cnt_r <= wait_cnt_r + 4'h1;
        end
        // one pulse, slow answer after the sp write
        wb_valid <= !rst && resync_pending && (wait_cnt_r == 4'h2);
    end
endmodule : exec_model

/* File: testbench.sv */
// Purpose: self-checking bench for the stack pointer tracker
// Assumes: expected offsets come from a tracked-offset model here
// Notes: a monitor compares each issued instruction against a queue
`timescale 1ns/1ps
module testbench;
    logic clk, rst, in_valid, in_ready, out_valid, out_ready, stall;
    logic out_use_tracked, out_wait_real_sp, wb_valid, resync_pending;
    sp_track_pkg::sp_class_e in_class, out_class;
    logic signed [15:0] in_delta, out_offset, off;
    logic [21:0] exp_q[$];
    int n_mismatch = 0;
    int num_checks = 0;
    stack_pointer_tracker #(.OFFSET_W(16)) dut (.clk(clk), .rst(rst), .in_valid(in_valid),
        .in_ready(in_ready), .in_class(in_class), .in_delta(in_delta), .out_valid(out_valid),
        .out_ready(out_ready), .out_class(out_class), .out_offset(out_offset),
        .out_use_tracked(out_use_tracked), .out_wait_real_sp(out_wait_real_sp),
        .wb_valid(wb_valid), .resync_pending(resync_pending));
    exec_model partner (.clk(clk), .rst(rst), .stall(stall), .resync_pending(resync_pending),
        .out_ready(out_ready), .wb_valid(wb_valid));
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[FAIL] %0t: got %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic stop_test();
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : stop_test
    always @(negedge clk) begin
        if (!rst && out_valid === 1'b1 && out_ready === 1'b1) begin
            if (exp_q.size() == 0) check(32'h1, 32'h0);
            else check({10'h0, out_class, out_offset, out_use_tracked, out_wait_real_sp},
                {10'h0, exp_q.pop_front()});
        end
    end
    // offers one instruction, returns at the edge that takes it
    task automatic issue(input sp_track_pkg::sp_class_e c, input logic signed [15:0] d);
        logic trk, dep;
        int n;
        trk = c inside {[sp_track_pkg::CLS_PUSH : sp_track_pkg::CLS_SP_MEM_NOIDX]};
        dep = c inside {[sp_track_pkg::CLS_ADDR_CALC_SP : sp_track_pkg::CLS_MCODE_SP]};
        exp_q.push_back({c, off, trk, dep});
        if (c inside {[sp_track_pkg::CLS_PUSH : sp_track_pkg::CLS_TEARDOWN]}) off = off + d;
        if (dep) off = 16'h0000;
        in_valid <= 1'b1;
        in_class <= c;
        in_delta <= d;
        n = 0;
        do begin @(negedge clk); n++; end while (in_ready !== 1'b1 && n < 50);
        check(in_ready, 32'h1);
        @(posedge clk);
    endtask : issue
    task automatic idle_drain();
        int n;
        in_valid <= 1'b0;
        for (n = 0; n < 50 && exp_q.size() != 0; n++) @(negedge clk);
        check(exp_q.size(), 0);
        @(posedge clk);
    endtask : idle_drain
    task automatic t_push_pop();
        issue(sp_track_pkg::CLS_PUSH, -16'sd8);
        issue(sp_track_pkg::CLS_PUSH, -16'sd8);
        issue(sp_track_pkg::CLS_OTHER, 16'sd12);
        issue(sp_track_pkg::CLS_POP, 16'sd8);
        issue(sp_track_pkg::CLS_PUSH, -16'sd16);
        idle_drain();
    endtask : t_push_pop
    task automatic t_call_ret();
        issue(sp_track_pkg::CLS_CALL, -16'sd8);
        issue(sp_track_pkg::CLS_SP_SRC, 16'sd5);
        issue(sp_track_pkg::CLS_SP_MEM_NOIDX, 16'sd5);
        issue(sp_track_pkg::CLS_RET, 16'sd24);
        issue(sp_track_pkg::CLS_TEARDOWN, 16'sd16);
        idle_drain();
    endtask : t_call_ret
    task automatic t_dep();
        issue(sp_track_pkg::CLS_PUSH, -16'sd8);
        issue(sp_track_pkg::CLS_ADDR_CALC_SP, 16'sd0);
        issue(sp_track_pkg::CLS_PUSH, -16'sd4);
        issue(sp_track_pkg::CLS_SP_MEM_IDX, 16'sd0);
        issue(sp_track_pkg::CLS_PUSH, -16'sd4);
        idle_drain();
    endtask : t_dep
    task automatic t_resync(input sp_track_pkg::sp_class_e c);
        issue(sp_track_pkg::CLS_PUSH, -16'sd8);
        issue(c, 16'sd0);
        in_valid <= 1'b0;
        @(negedge clk);
        check({resync_pending, in_ready}, 32'h2);
        @(posedge clk);
        issue(sp_track_pkg::CLS_PUSH, -16'sd8);
        idle_drain();
        check(resync_pending, 0);
    endtask : t_resync
    task automatic t_stall();
        stall <= 1'b1;
        issue(sp_track_pkg::CLS_PUSH, -16'sd8);
        in_valid <= 1'b0;
        repeat (3) begin
            @(negedge clk);
            check({out_valid, in_ready, out_offset}, {16'h2, off + 16'sd8});
        end
        @(posedge clk);
        stall <= 1'b0;
        idle_drain();
    endtask : t_stall
    initial begin
        rst = 1'b1;
        in_valid = 1'b0;
        in_class = sp_track_pkg::CLS_OTHER;
        in_delta = 16'h0000;
        stall = 1'b0;
        off = 16'h0000;
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        @(negedge clk);
        check({out_valid, in_ready, resync_pending}, 32'h2);
        @(posedge clk);
        t_push_pop();
        t_call_ret();
        t_dep();
        t_resync(sp_track_pkg::CLS_SP_DST);
        t_resync(sp_track_pkg::CLS_MCODE_SP);
        t_stall();
        stop_test();
    end
    initial begin
        repeat (3000) @(posedge clk);
        n_mismatch++;
        stop_test();
    end
endmodule : testbench
